// ===== bench/pmap_coupler.sv
// coupler model: classic Wishbone master that reads and writes image words
// assumes the slave acks every request; the bench timeout ends any hang
`timescale 1ns/1ns
module pmap_coupler (
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic [31:0] dat_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [7:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o
);
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'h0;
      dat_o = 32'h00000000;
   end

   // one request, held until ack; released address and data lines show the inverse of their last value, the rest go low
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      sel_o <= 4'hF;
      dat_o <= d;
      do @(posedge clk_i); while (ack_i !== 1'b1);
      r = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o <= 1'b0;
      adr_o <= ~a;
      sel_o <= 4'h0;
      dat_o <= ~d;
   endtask
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the byte mapper, walking every mapping setting
// assumes the coupler model drives the register bus
`timescale 1ns/1ns
module tb_top;
   localparam logic [7:0] OCT0 = 8'h11, OCT1 = 8'h22, OCT2 = 8'h33, OCT3 = 8'h44, STAT = 8'h5A;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc, stb, we, ack;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, rd;
   logic [31:0] data_octets_i = 32'h00000000;
   logic [7:0] stat_octet_i = 8'h00;
   logic [7:0] ctrl_octet_o;
   logic ctrl_valid_o, out_used_o, run_o;
   logic [3:0] image_bytes_o;
   int err_total = 0;
   int tests_run = 0;
   int cycles = 0;

   always #2 clk_i = ~clk_i;

   pmap_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .data_octets_i(data_octets_i), .stat_octet_i(stat_octet_i),
      .ctrl_octet_o(ctrl_octet_o), .ctrl_valid_o(ctrl_valid_o), .out_used_o(out_used_o),
      .image_bytes_o(image_bytes_o), .run_o(run_o));
   pmap_coupler u_cpl (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

   task automatic close_out();
      $display("compares %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   function automatic logic [15:0] exp_w(input logic [2:0] c, input int w);
      logic b;
      b = c[1];
      exp_w = 16'h0000;
      if (!c[0]) begin
         if (w == 0) exp_w = b ? {OCT0, OCT1} : {OCT1, OCT0};
         if (w == 1) exp_w = b ? {OCT2, OCT3} : {OCT3, OCT2};
      end else if (!c[2]) begin
         if (w == 0) exp_w = b ? {OCT1, STAT} : {OCT0, STAT};
         if (w == 1) exp_w = {8'h00, b ? OCT0 : OCT1};
         if (w == 2) exp_w = b ? {OCT2, OCT3} : {OCT3, OCT2};
      end else begin
         if (w == 0) exp_w = {8'h00, STAT};
         if (w == 1) exp_w = b ? {OCT0, OCT1} : {OCT1, OCT0};
         if (w == 3) exp_w = b ? {OCT2, OCT3} : {OCT3, OCT2};
      end
   endfunction

   task automatic settle();
      repeat (2) @(posedge clk_i);
   endtask

   task automatic sc_layouts();
      for (int c = 0; c < 8; c++) begin
         u_cpl.xfer(1'b1, 8'h00, c, rd);
         settle();
         chk({28'h0, image_bytes_o}, c[0] ? 32'h6 : 32'h4);
         chk({31'h0, out_used_o}, {31'h0, c[0]});
         chk({31'h0, ctrl_valid_o}, {31'h0, c[0]});
         u_cpl.xfer(1'b0, 8'h08, 32'h0, rd);
         chk({27'h0, rd[5], rd[3:0]}, {27'h0, c[0], c[0] ? 4'h6 : 4'h4});
         chk({29'h0, rd[10:8]}, {29'h0, !c[0] ? 3'h1 : (c[2] ? 3'h4 : 3'h2)});
         for (int w = 0; w < 4; w++) begin
            u_cpl.xfer(1'b0, 8'h10 + 8'(4 * w), 32'h0, rd);
            chk({16'h0, rd[15:0]}, {16'h0, exp_w(c[2:0], w)});
         end
      end
   endtask

   task automatic sc_ctrl();
      u_cpl.xfer(1'b1, 8'h00, 32'h0, rd);
      u_cpl.xfer(1'b1, 8'h20, 32'hA5, rd);
      settle();
      chk({24'h0, ctrl_octet_o}, 32'h0);
      u_cpl.xfer(1'b1, 8'h00, 32'h5, rd);
      u_cpl.xfer(1'b1, 8'h20, 32'hA5, rd);
      settle();
      chk({24'h0, ctrl_octet_o}, 32'hA5);
      u_cpl.xfer(1'b0, 8'h2C, 32'h0, rd);
      chk(rd, 32'h0);
      u_cpl.xfer(1'b1, 8'h00, 32'h4, rd);
      settle();
      chk({24'h0, ctrl_octet_o}, 32'h0);
      chk({31'h0, ctrl_valid_o}, 32'h0);
   endtask

   task automatic sc_lock();
      u_cpl.xfer(1'b1, 8'h04, 32'h1, rd);
      u_cpl.xfer(1'b1, 8'h00, 32'h2, rd);
      settle();
      chk({31'h0, run_o}, 32'h1);
      u_cpl.xfer(1'b0, 8'h00, 32'h0, rd);
      chk({29'h0, rd[2:0]}, 32'h4);
      u_cpl.xfer(1'b1, 8'h04, 32'h0, rd);
      u_cpl.xfer(1'b1, 8'h00, 32'h2, rd);
      u_cpl.xfer(1'b0, 8'h00, 32'h0, rd);
      chk({29'h0, rd[2:0]}, 32'h2);
   endtask

   always @(posedge clk_i) begin
      cycles++;
      if (cycles >= 20000) begin
         err_total++;
         close_out();
      end
   end

   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      data_octets_i <= {OCT3, OCT2, OCT1, OCT0};
      stat_octet_i <= STAT;
      @(posedge clk_i);
      chk({28'h0, image_bytes_o}, 32'h4);
      chk({29'h0, out_used_o, ctrl_valid_o, run_o}, 32'h0);
      sc_layouts();
      sc_ctrl();
      sc_lock();
      close_out();
   end
endmodule

// ===== hw/pmap_cfg.svh
// offsets, field positions, reset values and counts for the process image byte mapper
// assumes a 32-bit classic Wishbone slave with byte addresses
`ifndef PMAP_CFG_SVH
`define PMAP_CFG_SVH

`define PMAP_CFG_OFS 8'h00
`define PMAP_RUN_OFS 8'h04
`define PMAP_STAT_OFS 8'h08
`define PMAP_IN_BASE 8'h10
`define PMAP_OUT_BASE 8'h20

`define PMAP_CFG_FULL 0
`define PMAP_CFG_BIG 1
`define PMAP_CFG_ALIGN 2
`define PMAP_CFG_RST 8'h00
`define PMAP_CTRL_RST 8'h00

`define PMAP_BYTES_DATA 4'h4
`define PMAP_BYTES_FULL 4'h6
`define PMAP_WORDS 4

`endif

// ===== hw/pmap_octet_reg.sv
// one writable register with a write qualifier
// assumes wr_i and en_i come from logic on clk_i
`timescale 1ns/1ns
module pmap_octet_reg #(
   parameter int W = 8,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wr_i,
   input wire logic en_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] val_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         val_q <= RST;
      end else if (wr_i && en_i) begin
         val_q <= d_i;
      end
   end

   assign q_o = val_q;

endmodule

// ===== hw/pmap_pair.sv
// builds one process image word from two data octets in the chosen byte order
// assumes lo_i is the lower-numbered octet of the pair
`timescale 1ns/1ns
module pmap_pair (
   input wire logic [7:0] lo_i,
   input wire logic [7:0] hi_i,
   input wire logic big_i,
   output logic [15:0] word_o
);

   // little order puts the higher-numbered octet in the high byte
   assign word_o = big_i ? {lo_i, hi_i} : {hi_i, lo_i};

endmodule

// ===== hw/pmap_pkg.sv
// types shared by the process image byte mapper
// assumes pmap_cfg.svh supplies the numeric constants
package pmap_pkg;

   // placement family selected by the full and align mapping settings
   typedef enum logic [2:0] {
      PMAP_PLAIN = 3'b001,
      PMAP_PACKED = 3'b010,
      PMAP_ALIGNED = 3'b100
   } pmap_layout_type;

   typedef logic [15:0] pmap_word_type;

endpackage

// ===== hw/pmap_top.sv
// process image byte mapper: places the four data octets and the control and
// status octet into the coupler's word image; registers on classic Wishbone
// assumes data_octets_i and stat_octet_i come from logic on clk_i
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "pmap_cfg.svh"

// Summary of operation
// - image takes four data bytes, six with the control and status octet
// - full evaluation also occupies the output image, not only input
// - full evaluation maps the control/status octet before the data octets
// - byte order per word selectable, swapping high and low data octets
// - word alignment starts data words on word boundaries, padding unused bytes
// - control octet from output word 0 low, status into input word 0 low
// - unused byte positions are neither driven nor interpreted
// - plain little order: word0 = octet1:octet0, word1 = octet3:octet2
// - plain big order: word0 = octet0:octet1, word1 = octet2:octet3
// - full, little, aligned: word0 low status, word1 octet1:octet0, word3 octet3:octet2
module pmap_top
   import pmap_pkg::*;
#(
   parameter int AW = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [31:0] data_octets_i,
   input wire logic [7:0] stat_octet_i,
   output logic [7:0] ctrl_octet_o,
   output logic ctrl_valid_o,
   output logic out_used_o,
   output logic [3:0] image_bytes_o,
   output logic run_o
);

   logic ack_q;
   logic [31:0] rdat_q;
   logic [31:0] rdat_d;
   logic run_q;
   logic [7:0] ctrl_q;
   logic ctrl_valid_q;
   logic out_used_q;
   logic [3:0] bytes_q;
   logic [3:0] bytes_d;
   logic [7:0] cfg;
   logic [7:0] ctrl_raw;
   logic req;
   logic wr;
   logic full;
   logic big;
   logic align;
   pmap_layout_type layout;
   pmap_word_type pair_lo;
   pmap_word_type pair_hi;
   pmap_word_type in_w [`PMAP_WORDS];
   logic [7:0] oct0, oct1, oct2, oct3;

   assign oct0 = data_octets_i[7:0];
   assign oct1 = data_octets_i[15:8];
   assign oct2 = data_octets_i[23:16];
   assign oct3 = data_octets_i[31:24];

   // bus handshake: ack one cycle after request, write at the edge ack is sampled
   assign req = wb_cyc_i && wb_stb_i;
   assign wr = req && wb_we_i && ack_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req && !ack_q;
      end
   end

   // mapping settings held static while exchange runs
   pmap_octet_reg #(
      .W(8),
      .RST(`PMAP_CFG_RST)
   ) u_cfg (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(wr && wb_sel_i[0] && wb_adr_i == `PMAP_CFG_OFS),
      .en_i(!run_q),
      .d_i(wb_dat_i[7:0]),
      .q_o(cfg)
   );

   assign full = cfg[`PMAP_CFG_FULL];
   assign big = cfg[`PMAP_CFG_BIG];
   assign align = cfg[`PMAP_CFG_ALIGN];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_q <= 1'b0;
      end else if (wr && wb_sel_i[0] && wb_adr_i == `PMAP_RUN_OFS) begin
         run_q <= wb_dat_i[0];
      end
   end

   // control octet lives in the low byte of output word 0, only with full evaluation
   pmap_octet_reg #(
      .W(8),
      .RST(`PMAP_CTRL_RST)
   ) u_ctrl (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(wr && wb_sel_i[0] && wb_adr_i == `PMAP_OUT_BASE),
      .en_i(full),
      .d_i(wb_dat_i[7:0]),
      .q_o(ctrl_raw)
   );

   always_comb begin
      if (!full) begin
         layout = PMAP_PLAIN;
      end else if (align) begin
         layout = PMAP_ALIGNED;
      end else begin
         layout = PMAP_PACKED;
      end
   end

   // the two data words share one byte order selector
   pmap_pair u_pair_lo (
      .lo_i(oct0),
      .hi_i(oct1),
      .big_i(big),
      .word_o(pair_lo)
   );

   pmap_pair u_pair_hi (
      .lo_i(oct2),
      .hi_i(oct3),
      .big_i(big),
      .word_o(pair_hi)
   );

   // input image placement; unused bytes read as zero
   always_comb begin
      in_w[0] = 16'h0000;
      in_w[1] = 16'h0000;
      in_w[2] = 16'h0000;
      in_w[3] = 16'h0000;
      case (layout)
         PMAP_PLAIN: begin
            in_w[0] = pair_lo;
            in_w[1] = pair_hi;
         end
         PMAP_PACKED: begin
            // status first, octets 0 and 1 follow byte by byte, word 1 high stays zero, octets 2 and 3 fill word 2
            in_w[0] = {big ? oct1 : oct0, stat_octet_i};
            in_w[1] = {8'h00, big ? oct0 : oct1};
            in_w[2] = pair_hi;
         end
         PMAP_ALIGNED: begin
            in_w[0] = {8'h00, stat_octet_i};
            in_w[1] = pair_lo;
            in_w[3] = pair_hi;
         end
         default: begin
            in_w[0] = 16'h0000;
         end
      endcase
   end

   always_comb begin
      bytes_d = full ? `PMAP_BYTES_FULL : `PMAP_BYTES_DATA;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bytes_q <= `PMAP_BYTES_DATA;
         out_used_q <= 1'b0;
      end else begin
         bytes_q <= bytes_d;
         out_used_q <= full;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= `PMAP_CTRL_RST;
         ctrl_valid_q <= 1'b0;
      end else begin
         ctrl_q <= full ? ctrl_raw : 8'h00;
         ctrl_valid_q <= full;
      end
   end

   // read mux; unmapped addresses and output image words read as zero
   always_comb begin
      rdat_d = 32'h0000_0000;
      case (wb_adr_i)
         `PMAP_CFG_OFS: rdat_d = {24'h000000, cfg};
         `PMAP_RUN_OFS: rdat_d = {31'h0000_0000, run_q};
         `PMAP_STAT_OFS: rdat_d = {16'h0000, 5'h00, layout, 2'h0, out_used_q, 1'b0, bytes_q};
         `PMAP_IN_BASE: rdat_d = {16'h0000, in_w[0]};
         `PMAP_IN_BASE + 8'h04: rdat_d = {16'h0000, in_w[1]};
         `PMAP_IN_BASE + 8'h08: rdat_d = {16'h0000, in_w[2]};
         `PMAP_IN_BASE + 8'h0C: rdat_d = {16'h0000, in_w[3]};
         default: rdat_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_q <= 32'h0000_0000;
      end else if (req && !ack_q && !wb_we_i) begin
         rdat_q <= rdat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign ctrl_octet_o = ctrl_q;
   assign ctrl_valid_o = ctrl_valid_q;
   assign out_used_o = out_used_q;
   assign image_bytes_o = bytes_q;
   assign run_o = run_q;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence ctrl_write_s;
      wr && wb_sel_i[0] && wb_adr_i == `PMAP_OUT_BASE && full;
   endsequence

   sequence ctrl_seen_s;
      ##2 ctrl_octet_o == $past(wb_dat_i[7:0], 2);
   endsequence

   // bus requests are answered by a single ack pulse
   sequence bus_take_s;
      req && !ack_q;
   endsequence

   sequence bus_answer_s;
      ##1 wb_ack_o ##1 !wb_ack_o;
   endsequence

   sequence stat_read_s;
      req && !ack_q && !wb_we_i && wb_adr_i == `PMAP_IN_BASE && full;
   endsequence

   sequence cfg_write_s;
      wr && wb_sel_i[0] && wb_adr_i == `PMAP_CFG_OFS && !run_q;
   endsequence

   byte_count_a: assert property (
      ##1 image_bytes_o == ($past(full) ? `PMAP_BYTES_FULL : `PMAP_BYTES_DATA))
      else $error("image byte count does not match evaluation mode");

   bytes_pair_a: assert property (
      image_bytes_o == (out_used_o ? `PMAP_BYTES_FULL : `PMAP_BYTES_DATA))
      else $error("image byte count and output image use disagree");

   out_image_a: assert property ($changed(full) |=> out_used_o == full)
      else $error("output image use does not follow evaluation mode");

   status_first_a: assert property (full |-> in_w[0][7:0] == stat_octet_i)
      else $error("status octet not at word 0 low");

   plain_layout_a: assert property (!full |-> layout == PMAP_PLAIN)
      else $error("layout without full evaluation is not plain");

   layout_hot_a: assert property ($onehot(layout))
      else $error("layout selector not one-hot");

   order_swap_a: assert property (
      !full |-> in_w[0] == (big ? {oct0, oct1} : {oct1, oct0})
         && in_w[1] == (big ? {oct2, oct3} : {oct3, oct2}))
      else $error("byte order within data words wrong");

   packed_little_a: assert property (
      full && !align && !big |-> in_w[0] == {oct0, stat_octet_i}
         && in_w[1] == {8'h00, oct1} && in_w[2] == {oct3, oct2})
      else $error("packed little layout wrong");

   packed_big_a: assert property (
      full && !align && big |-> in_w[0] == {oct1, stat_octet_i}
         && in_w[1] == {8'h00, oct0} && in_w[2] == {oct2, oct3})
      else $error("packed big layout wrong");

   align_pad_a: assert property (
      full && align |-> in_w[2] == 16'h0000 && in_w[0][15:8] == 8'h00)
      else $error("aligned layout does not pad word 2 and word 0 high");

   aligned_big_a: assert property (
      full && align && big |-> in_w[0] == {8'h00, stat_octet_i}
         && in_w[1] == {oct0, oct1} && in_w[3] == {oct2, oct3})
      else $error("full aligned big layout wrong");

   ctrl_take_a: assert property (ctrl_write_s |-> ctrl_seen_s)
      else $error("control octet not taken from output word 0 low");

   valid_follow_a: assert property (1'b1 |=> ctrl_valid_o == $past(full))
      else $error("control octet valid does not follow evaluation mode");

   stat_read_a: assert property (stat_read_s |=> wb_dat_o[7:0] == $past(stat_octet_i))
      else $error("status octet not read back from input word 0 low");

   unused_ctrl_a: assert property (!full |=> ctrl_valid_o == 1'b0 && ctrl_octet_o == 8'h00)
      else $error("control octet interpreted without full evaluation");

   ctrl_ignored_a: assert property (
      wr && wb_adr_i == `PMAP_OUT_BASE && !full |=> $stable(ctrl_raw))
      else $error("control octet taken without full evaluation");

   unused_plain_a: assert property (
      !full |-> in_w[2] == 16'h0000 && in_w[3] == 16'h0000)
      else $error("unused words driven in plain layout");

   unused_packed_a: assert property (
      full && !align |-> in_w[1][15:8] == 8'h00 && in_w[3] == 16'h0000)
      else $error("unused bytes driven in packed layout");

   plain_little_a: assert property (
      !full && !big |-> in_w[0] == {oct1, oct0} && in_w[1] == {oct3, oct2}
         && in_w[2] == 16'h0000)
      else $error("plain little layout wrong");

   plain_big_a: assert property (
      !full && big |-> in_w[0] == {oct0, oct1} && in_w[1] == {oct2, oct3}
         && in_w[3] == 16'h0000)
      else $error("plain big layout wrong");

   full_aligned_a: assert property (
      full && !big && align |-> in_w[1] == {oct1, oct0} && in_w[3] == {oct3, oct2})
      else $error("full aligned little layout wrong");

   cfg_frozen_a: assert property (run_q |=> $stable(cfg))
      else $error("mapping settings changed while exchange runs");

   cfg_lands_a: assert property (cfg_write_s |=> cfg == $past(wb_dat_i[7:0]))
      else $error("mapping settings write did not land while stopped");

   ack_pulse_a: assert property (bus_take_s |-> bus_answer_s)
      else $error("bus request not answered by a single ack pulse");

   ack_cause_a: assert property (wb_ack_o |-> $past(req) && !$past(wb_ack_o))
      else $error("ack without a preceding request");

endmodule
